// *** bench/scce_channel_tb.sv ***
// Self-checking bench for the selector channel engine.
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR %s exp %h got %h", n, e, g); end end
module scce_channel_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 1'b0, reset_n_in = 1'b0, xv = 1'b0, sreq = 1'b0, endr = 1'b0, sm = 1'b0;
    logic [2:0] xf = 3'h0;
    logic [15:0] xm = 16'h0, xa = 16'h0, acc, maddr, mwd, mrd;
    logic [7:0] uadr = 8'h0, ust = 8'h0, base, cmd, dev, rxd, txd;
    logic done, irq, busy, mreq, mwe, mg, cv, halt, dend, smo, rxv, rxr, txv;
    int n_errors = 0;
    int comparisons = 0;
    int seed = 32'h393f;
    int wr = 0;
    int ntx = 0;
    logic cub = 1'b0;
    wire logic [3:0] cond = {wr == 2, busy === 1'b0, cv === 1'b1, irq === 1'b1};
    logic [16:0] q[$];
    logic [15:0] fa[$];
    logic [16:0] e;
    always #50 clk_in = ~clk_in;
    scce_channel uut (.clk_in(clk_in), .reset_n_in(reset_n_in), .xio_valid_in(xv),
        .xio_func_in(xf), .xio_modifier_in(xm), .xio_address_in(xa), .xio_accum_out(acc),
        .xio_done_out(done), .irq_out(irq), .busy_out(busy), .mem_req_out(mreq),
        .mem_we_out(mwe), .mem_addr_out(maddr), .mem_wdata_out(mwd), .mem_grant_in(mg),
        .mem_rdata_in(mrd), .cu_cmd_valid_out(cv), .cu_cmd_out(cmd), .cu_dev_addr_out(dev),
        .cu_halt_out(halt), .cu_busy_in(cub), .cu_service_req_in(sreq),
        .cu_unit_addr_in(uadr), .cu_unit_status_in(ust), .cu_dev_end_in(dend),
        .cu_status_mod_in(smo), .cu_unit_check_in(1'b0), .cu_rx_valid_in(rxv),
        .cu_rx_data_in(rxd), .cu_rx_ready_out(rxr), .cu_tx_valid_out(txv),
        .cu_tx_data_out(txd), .cu_tx_ready_in(1'b1));
    scce_partner pm (.clk_in(clk_in), .reset_n_in(reset_n_in), .mem_req_in(mreq),
        .mem_we_in(mwe), .mem_addr_in(maddr), .mem_wdata_in(mwd), .mem_grant_out(mg),
        .mem_rdata_out(mrd), .cmd_valid_in(cv), .cmd_in(cmd), .end_in(endr), .sm_in(sm),
        .rx_base_in(base), .rx_valid_out(rxv), .rx_data_out(rxd), .rx_ready_in(rxr),
        .dev_end_out(dend), .sm_out(smo));
    // Results are matched against the oldest note when a function completes and that note has its check bit set.
    always @(posedge clk_in) begin
        if (mg && !mwe) fa.push_back(maddr);
        if (mg && mwe) wr++;
        if (txv === 1'b1) begin
            `CHK("tx", base + 8'(ntx), txd)
            ntx++;
        end
        if (done === 1'b1 && q.size() > 0) begin
            e = q.pop_front();
            if (e[16]) `CHK("accum", e[15:0], acc)
        end
    end
    task automatic tally_and_finish();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic execute_io_instruction(input logic [2:0] f, input logic [15:0] m, a, input logic [16:0] x);
        @(posedge clk_in);
        xv <= 1'b1;
        xf <= f;
        xm <= m;
        xa <= a;
        q.push_back(x);
        @(posedge clk_in);
        xv <= 1'b0;
    endtask
    // A wait that runs out is counted and closes the run.
    task automatic wait_on(input int w);
        for (int i = 0; i < 400; i++) begin
            @(negedge clk_in);
            if (cond[w]) begin
                @(posedge clk_in);
                return;
            end
        end
        n_errors++;
        tally_and_finish();
    endtask
    task automatic dev_end(input logic s);
        @(posedge clk_in);
        endr <= 1'b1;
        sm <= s;
        @(posedge clk_in);
        endr <= 1'b0;
        sm <= 1'b0;
    endtask
    initial begin
        pm.mem[32] = 16'h0004;
        pm.mem[33] = 16'h5003;
        pm.mem[34] = 16'h0080;
        pm.mem[38] = 16'h0004;
        pm.mem[39] = 16'h0002;
        pm.mem[40] = 16'h0090;
        pm.mem[44] = 16'h0002;
        pm.mem[45] = 16'h2001;
        pm.mem[46] = 16'h0090;
        base = 8'($random(seed));
        repeat (4) @(posedge clk_in);
        reset_n_in <= 1'b1;
        execute_io_instruction(3'h3, 16'h0000, 16'h0000, 17'h10000);
        sreq <= 1'b1;
        uadr <= 8'h5a;
        ust <= 8'h0c;
        wait_on(0);
        sreq <= 1'b0;
        execute_io_instruction(3'h3, 16'h0000, 16'h0000, 17'h18000);
        execute_io_instruction(3'h7, 16'h0000, 16'h0000, 17'h15a0c);
        execute_io_instruction(3'h7, 16'h0008, 16'h0000, 17'h00000);
        sreq <= 1'b1;
        uadr <= 8'h33;
        repeat (5) @(posedge clk_in);
        execute_io_instruction(3'h7, 16'h0001, 16'h0000, 17'h15a0c);
        sreq <= 1'b0;
        $display("polling test done");
        execute_io_instruction(3'h5, 16'h0007, 16'h0020, 17'h00000);
        wait_on(1);
        `CHK("cmd", 8'h03, cmd)
        `CHK("dev", 8'h07, dev)
        execute_io_instruction(3'h7, 16'h0006, 16'h0000, 17'h10020);
        dev_end(1'b1);
        wait_on(1);
        `CHK("cmd2", 8'h02, cmd)
        `CHK("fetch2", 16'h0022, fa[2])
        `CHK("fetch3", 16'h0026, fa[3])
        wait_on(3);
        `CHK("word0", {base, base + 8'h01}, pm.mem[144])
        `CHK("word1", {base + 8'h02, base + 8'h03}, pm.mem[145])
        dev_end(1'b0);
        wait_on(2);
        `CHK("irq", 1'b1, irq)
        execute_io_instruction(3'h7, 16'h0003, 16'h0000, 17'h1cc00);
        $display("chain test done");
        execute_io_instruction(3'h5, 16'h0007, 16'h0026, 17'h00000);
        wait_on(1);
        execute_io_instruction(3'h4, 16'h00ff, 16'h0000, 17'h00000);
        @(negedge clk_in);
        `CHK("halt_x", 1'b1, halt)
        wait_on(2);
        `CHK("irq_halt", 1'b1, irq)
        execute_io_instruction(3'h7, 16'h0003, 16'h0000, 17'h1c100);
        $display("halt test done");
        execute_io_instruction(3'h5, 16'h0007, 16'h002c, 17'h00000);
        wait_on(1);
        repeat (20) @(posedge clk_in);
        dev_end(1'b0);
        wait_on(2);
        `CHK("tx_count", 2, ntx)
        execute_io_instruction(3'h7, 16'h0003, 16'h0000, 17'h1c000);
        $display("write test done");
        cub <= 1'b1;
        execute_io_instruction(3'h4, 16'h00a5, 16'h0000, 17'h00000);
        @(negedge clk_in);
        `CHK("halt_i", 1'b1, halt)
        `CHK("dev_i", 8'ha5, dev)
        $display("idle halt test done");
        tally_and_finish();
    end
endmodule

// *** bench/scce_partner.sv ***
// Storage and disk control unit models facing the channel.
module scce_partner (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Storage side, granted after a varying delay.
    input wire logic mem_req_in,
    input wire logic mem_we_in,
    input wire logic [15:0] mem_addr_in,
    input wire logic [15:0] mem_wdata_in,
    output logic mem_grant_out,
    output logic [15:0] mem_rdata_out,
    // Control unit side.
    input wire logic cmd_valid_in,
    input wire logic [7:0] cmd_in,
    input wire logic end_in,
    input wire logic sm_in,
    input wire logic [7:0] rx_base_in,
    output logic rx_valid_out,
    output logic [7:0] rx_data_out,
    input wire logic rx_ready_in,
    output logic dev_end_out,
    output logic sm_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [0:255];
    logic tog;
    // The grant alternates between prompt and slow so both latencies are exercised.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tog <= 1'b0;
            mem_grant_out <= 1'b0;
            rx_valid_out <= 1'b0;
            dev_end_out <= 1'b0;
            sm_out <= 1'b0;
        end else begin
            tog <= ~tog;
            mem_grant_out <= mem_req_in && !mem_grant_out && tog;
            dev_end_out <= end_in;
            sm_out <= sm_in;
            if (cmd_valid_in && cmd_in[1:0] == 2'h2) rx_valid_out <= 1'b1;
            if (end_in) rx_valid_out <= 1'b0;
        end
    end
    // Idle data lines toggle so a stale value is never mistaken for fresh data.
    always @(posedge clk_in) begin
        mem_rdata_out <= (mem_req_in && tog) ? mem[mem_addr_in[7:0]] : ~mem_rdata_out;
        if (mem_grant_out && mem_we_in) mem[mem_addr_in[7:0]] <= mem_wdata_in;
        if (cmd_valid_in) rx_data_out <= rx_base_in;
        else if (!rx_valid_out) rx_data_out <= ~rx_data_out;
        else if (rx_ready_in) rx_data_out <= rx_data_out + 8'h01;
    end
endmodule

// *** common/scce_pkg.sv ***
// Shared types of the selector channel engine.
package scce_pkg;
    typedef enum logic [2:0] {
        OP_WRITE, OP_READ, OP_CONTROL, OP_SENSE, OP_TIC, OP_TEST, OP_INVALID
    } scce_op_type;
    typedef enum logic [2:0] {
        ST_IDLE, ST_FETCH, ST_ISSUE, ST_XFER, ST_WAIT_END
    } scce_state_type;
endpackage

// *** common/scce_regs.svh ***
// Constants of the selector channel command word engine.
`ifndef SCCE_REGS_SVH
`define SCCE_REGS_SVH
`define SCCE_FN_SENSE_INT 3'h3
`define SCCE_FN_HALT 3'h4
`define SCCE_FN_START 3'h5
`define SCCE_FN_SENSE_ST 3'h7
`define SCCE_MOD_DEV 7:0
`define SCCE_MOD_POLL 3
`define SCCE_MOD_SEL 2:1
`define SCCE_MOD_RESET 0
`define SCCE_SW_UNIT 2'h0
`define SCCE_SW_FLAGS 2'h1
`define SCCE_SW_COUNT 2'h2
`define SCCE_W_FLAGS 15:11
`define SCCE_W_PCI 12
`define SCCE_W_CMD 7:0
`define SCCE_F_CD 4
`define SCCE_F_CC 3
`define SCCE_F_SLI 2
`define SCCE_F_SKIP 0
`define SCCE_CMD_LOW2 1:0
`define SCCE_CMD_LOW4 3:0
`define SCCE_CC_WRITE 2'h1
`define SCCE_CC_READ 2'h2
`define SCCE_CC_CONTROL 2'h3
`define SCCE_CC_SENSE 4'h4
`define SCCE_CC_TIC 4'h8
`define SCCE_CC_TEST 4'h0
`define SCCE_CC_READ_BACK 4'hc
`define SCCE_CCW_STEP 16'h0003
`define SCCE_CCW_SKIP_STEP 16'h0006
`define SCCE_CLK_NS 100
`define SCCE_RESP_NS 3000
`define SCCE_RESP_CYC (`SCCE_RESP_NS / `SCCE_CLK_NS)
`endif

// *** rtl/scce_channel.sv ***
// Selector channel engine: command words, cycle stealing, polling and status.
`include "scce_regs.svh"
module scce_channel #(
    parameter int FIFO_DEPTH = 16
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Execute-I/O command port.
    input wire logic xio_valid_in,
    input wire logic [2:0] xio_func_in,
    input wire logic [15:0] xio_modifier_in,
    input wire logic [15:0] xio_address_in,
    output logic [15:0] xio_accum_out,
    output logic xio_done_out,
    output logic irq_out,
    output logic busy_out,
    // Cycle-steal port to main storage.
    output logic mem_req_out,
    output logic mem_we_out,
    output logic [15:0] mem_addr_out,
    output logic [15:0] mem_wdata_out,
    input wire logic mem_grant_in,
    input wire logic [15:0] mem_rdata_in,
    // Control unit commands, halt, polling and ending.
    output logic cu_cmd_valid_out,
    output logic [7:0] cu_cmd_out,
    output logic [7:0] cu_dev_addr_out,
    output logic cu_halt_out,
    input wire logic cu_busy_in,
    input wire logic cu_service_req_in,
    input wire logic [7:0] cu_unit_addr_in,
    input wire logic [7:0] cu_unit_status_in,
    input wire logic cu_dev_end_in,
    input wire logic cu_status_mod_in,
    input wire logic cu_unit_check_in,
    // Control unit data bytes.
    input wire logic cu_rx_valid_in,
    input wire logic [7:0] cu_rx_data_in,
    output logic cu_rx_ready_out,
    output logic cu_tx_valid_out,
    output logic [7:0] cu_tx_data_out,
    input wire logic cu_tx_ready_in
);
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);

    localparam int RESP_INT = `SCCE_RESP_CYC;
    localparam logic [5:0] RESP_CYC = 6'(RESP_INT);
    if (RESP_INT < 1 || RESP_INT > 63 || FIFO_DEPTH < 2) begin : g_bad_param
        $error("Response count or buffer depth out of range.");
    end

    function automatic logic [15:0] ccw_next(input logic [15:0] a, input logic [15:0] d);
        return a + d;
    endfunction

    scce_pkg::scce_state_type state;
    scce_pkg::scce_state_type next_state;
    scce_pkg::scce_op_type op;
    scce_pkg::scce_op_type fetched_op;
    logic [1:0] fetch_idx;
    logic [15:0] ccw_addr;
    logic [15:0] count;
    logic [15:0] data_addr;
    logic [15:0] word_buf;
    logic [4:0] flags;
    logic [7:0] cmd;
    logic [7:0] unit_addr;
    logic [7:0] unit_status;
    logic dchain;
    logic tic_hit;
    logic half;
    logic pend_wr;
    logic tx_have;
    logic int_req;
    logic status_pending;
    logic poll_off;
    logic len_err;
    logic pci_seen;
    logic overrun;
    logic halted;
    logic [5:0] resp_cnt;
    logic f_valid;
    logic [7:0] f_data;
    logic fifo_in_ready;

    scce_decode u_dec_cur (
        .cmd_in(cmd),
        .op_out(op)
    );
    scce_decode u_dec_fetch (
        .cmd_in(mem_rdata_in[`SCCE_W_CMD]),
        .op_out(fetched_op)
    );

    // Function decoding.
    wire logic fn_sense_int = xio_valid_in && xio_func_in == `SCCE_FN_SENSE_INT;
    wire logic fn_halt = xio_valid_in && xio_func_in == `SCCE_FN_HALT;
    wire logic fn_start = xio_valid_in && xio_func_in == `SCCE_FN_START;
    wire logic fn_sense = xio_valid_in && xio_func_in == `SCCE_FN_SENSE_ST;
    wire logic idle = state == scce_pkg::ST_IDLE;
    wire logic in_fetch = state == scce_pkg::ST_FETCH;
    wire logic in_xfer = state == scce_pkg::ST_XFER;
    wire logic start_ok = fn_start && idle;
    wire logic halt_busy = fn_halt && !idle;
    wire logic halt_idle = fn_halt && idle && cu_busy_in;
    wire logic [1:0] sw_sel = xio_modifier_in[`SCCE_MOD_SEL];
    wire logic sw_reset = fn_sense && xio_modifier_in[`SCCE_MOD_RESET];
    wire logic read_unit = fn_sense && sw_sel == `SCCE_SW_UNIT;

    // Command word flags and operation class.
    wire logic f_cd = flags[`SCCE_F_CD];
    wire logic f_cc = flags[`SCCE_F_CC];
    wire logic f_sli = flags[`SCCE_F_SLI];
    wire logic f_skip = flags[`SCCE_F_SKIP];
    wire logic is_rd = op == scce_pkg::OP_READ || op == scce_pkg::OP_SENSE;
    wire logic is_wr = op == scce_pkg::OP_WRITE;
    wire logic immediate = !is_rd && !is_wr;
    wire logic last = count == 16'h0001;

    // Data movement.
    wire logic rd_open = in_xfer && is_rd && !pend_wr && count != 16'h0000;
    wire logic fifo_pop = rd_open && f_valid;
    wire logic tx_take = cu_tx_valid_out && cu_tx_ready_in;
    wire logic need_word = in_xfer && is_wr && !tx_have && count != 16'h0000;
    wire logic wr_store = in_xfer && pend_wr && !f_skip;
    wire logic skip_drop = in_xfer && pend_wr && f_skip;
    wire logic grant = mem_req_out && mem_grant_in;
    wire logic data_done = in_xfer && count == 16'h0000 && !pend_wr;
    wire logic pci_fetch = in_fetch && grant && fetch_idx == 2'h1 && mem_rdata_in[`SCCE_W_PCI];

    // Ending and chaining.
    wire logic dev_end = cu_dev_end_in && (in_xfer || state == scce_pkg::ST_WAIT_END);
    wire logic mismatch = !immediate && (count != 16'h0000 || f_valid);
    wire logic post_len = mismatch && !(f_sli && !f_cd);
    wire logic chain_ok = f_cc && !f_cd && op != scce_pkg::OP_TEST
        && !cu_unit_check_in && (!mismatch || f_sli);
    wire logic op_end = dev_end && !chain_ok && !halt_busy;
    wire logic poll_hit = idle && !poll_off && !status_pending && cu_service_req_in;
    wire logic waiting = in_xfer
        && ((is_rd && cu_rx_valid_in && !cu_rx_ready_out) || (is_wr && cu_tx_ready_in && !tx_have));

    wire logic [15:0] flag_word = {int_req, status_pending, !idle, poll_off,
        len_err, pci_seen, overrun, halted, 8'h00};
    wire logic [15:0] sw_word = sw_sel == `SCCE_SW_UNIT ? {unit_addr, unit_status} :
        sw_sel == `SCCE_SW_FLAGS ? flag_word :
        sw_sel == `SCCE_SW_COUNT ? count : ccw_addr;

    // Storage is only ever touched by stolen cycles while the channel is active.
    assign mem_req_out = in_fetch || need_word || wr_store;
    assign mem_we_out = wr_store;
    assign mem_addr_out = in_fetch ? ccw_next(ccw_addr, {14'h0000, fetch_idx}) : data_addr;
    assign mem_wdata_out = word_buf;
    assign cu_cmd_valid_out = state == scce_pkg::ST_ISSUE;
    assign cu_cmd_out = cmd;
    assign cu_rx_ready_out = fifo_in_ready && in_xfer && is_rd;
    assign cu_tx_valid_out = in_xfer && is_wr && tx_have;
    assign cu_tx_data_out = half ? word_buf[7:0] : word_buf[15:8];
    assign irq_out = int_req;
    assign busy_out = !idle;

    // The buffer absorbs bytes while a stolen cycle waits for its grant.
    scce_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .flush_in(start_ok || halt_busy || op_end),
        .in_valid_in(cu_rx_valid_in && in_xfer && is_rd),
        .in_data_in(cu_rx_data_in),
        .in_ready_out(fifo_in_ready),
        .out_valid_out(f_valid),
        .out_data_out(f_data),
        .out_ready_in(rd_open)
    );

    always_comb begin
        next_state = state;
        unique case (state)
            scce_pkg::ST_IDLE: if (start_ok) next_state = scce_pkg::ST_FETCH;
            scce_pkg::ST_FETCH: begin
                if (grant && fetch_idx == 2'h2 && !tic_hit) begin
                    next_state = dchain ? scce_pkg::ST_XFER : scce_pkg::ST_ISSUE;
                end
            end
            scce_pkg::ST_ISSUE: begin
                next_state = immediate ? scce_pkg::ST_WAIT_END : scce_pkg::ST_XFER;
            end
            scce_pkg::ST_XFER: begin
                if (data_done) begin
                    next_state = f_cd ? scce_pkg::ST_FETCH : scce_pkg::ST_WAIT_END;
                end
            end
            scce_pkg::ST_WAIT_END: next_state = state;
        endcase
        if (dev_end) begin
            next_state = chain_ok ? scce_pkg::ST_FETCH : scce_pkg::ST_IDLE;
        end
        if (halt_busy) begin
            next_state = scce_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state <= scce_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Command word address and fetch sequencing.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ccw_addr <= 16'h0000;
            fetch_idx <= 2'h0;
            dchain <= 1'b0;
            tic_hit <= 1'b0;
        end else if (halt_busy) begin
            fetch_idx <= 2'h0;
            dchain <= 1'b0;
        end else if (start_ok) begin
            ccw_addr <= xio_address_in;
            fetch_idx <= 2'h0;
            dchain <= 1'b0;
        end else if (in_fetch && grant) begin
            fetch_idx <= fetch_idx == 2'h2 ? 2'h0 : fetch_idx + 2'h1;
            if (fetch_idx == 2'h1) tic_hit <= fetched_op == scce_pkg::OP_TIC;
            if (fetch_idx == 2'h2 && tic_hit) ccw_addr <= mem_rdata_in;
        end else if (dev_end) begin
            ccw_addr <= ccw_next(ccw_addr, cu_status_mod_in ?
                `SCCE_CCW_SKIP_STEP : `SCCE_CCW_STEP);
            dchain <= 1'b0;
        end else if (data_done && f_cd) begin
            ccw_addr <= ccw_next(ccw_addr, `SCCE_CCW_STEP);
            dchain <= 1'b1;
        end
    end

    // Command word fields, byte count and data address.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            count <= 16'h0000;
            flags <= 5'h00;
            cmd <= 8'h00;
            data_addr <= 16'h0000;
        end else if (in_fetch && grant) begin
            if (fetch_idx == 2'h0) count <= mem_rdata_in;
            if (fetch_idx == 2'h1) flags <= mem_rdata_in[`SCCE_W_FLAGS];
            if (fetch_idx == 2'h1 && (!dchain || fetched_op == scce_pkg::OP_TIC)) begin
                cmd <= mem_rdata_in[`SCCE_W_CMD];
            end
            if (fetch_idx == 2'h2) data_addr <= mem_rdata_in;
        end else begin
            if (fifo_pop || tx_take) count <= count - 16'h0001;
            if ((in_xfer && grant) || skip_drop) data_addr <= data_addr + 16'h0001;
        end
    end

    // Byte packing: first byte fills the high half; an odd last byte pads with zero.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            word_buf <= 16'h0000;
            half <= 1'b0;
            pend_wr <= 1'b0;
            tx_have <= 1'b0;
        end else if (start_ok || halt_busy || !in_xfer) begin
            half <= 1'b0;
            pend_wr <= 1'b0;
            tx_have <= 1'b0;
        end else if (fifo_pop) begin
            word_buf <= half ? {word_buf[15:8], f_data} : {f_data, 8'h00};
            half <= !half && !last;
            pend_wr <= half || last;
        end else if (need_word && mem_grant_in) begin
            word_buf <= mem_rdata_in;
            tx_have <= 1'b1;
            half <= 1'b0;
        end else if (tx_take) begin
            half <= !half && !last;
            tx_have <= !(half || last);
        end else if ((wr_store && mem_grant_in) || skip_drop) begin
            pend_wr <= 1'b0;
        end
    end

    // Service response timer; a stall past the limit is recorded as overrun.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            resp_cnt <= 6'h00;
        end else if (!waiting) begin
            resp_cnt <= 6'h00;
        end else if (resp_cnt != RESP_CYC) begin
            resp_cnt <= resp_cnt + 6'h01;
        end
    end

    // Status flags: a setting event always wins over a clear in the same cycle.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            int_req <= 1'b0;
            status_pending <= 1'b0;
            poll_off <= 1'b0;
            len_err <= 1'b0;
            pci_seen <= 1'b0;
            overrun <= 1'b0;
            halted <= 1'b0;
        end else begin
            int_req <= op_end || halt_busy || poll_hit || pci_fetch
                || (int_req && !sw_reset);
            status_pending <= op_end || poll_hit || (status_pending && !read_unit);
            poll_off <= fn_sense ? xio_modifier_in[`SCCE_MOD_POLL] : poll_off && !op_end;
            len_err <= (op_end && post_len) || (len_err && !sw_reset);
            pci_seen <= pci_fetch || (pci_seen && !sw_reset);
            overrun <= resp_cnt == RESP_CYC || (overrun && !sw_reset);
            halted <= halt_busy || (halted && !sw_reset);
        end
    end

    // Unit latches, device address, halt strobe and accumulator answers.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            unit_addr <= 8'h00;
            unit_status <= 8'h00;
            cu_dev_addr_out <= 8'h00;
            cu_halt_out <= 1'b0;
            xio_accum_out <= 16'h0000;
            xio_done_out <= 1'b0;
        end else begin
            if (op_end || poll_hit) begin
                unit_addr <= cu_unit_addr_in;
                unit_status <= cu_unit_status_in;
            end
            if (start_ok || halt_idle) begin
                cu_dev_addr_out <= xio_modifier_in[`SCCE_MOD_DEV];
            end
            cu_halt_out <= halt_busy || halt_idle;
            if (fn_sense_int) xio_accum_out <= {int_req, 15'h0000};
            if (fn_sense) xio_accum_out <= sw_word;
            xio_done_out <= xio_valid_in;
        end
    end

    sequence chain_evt_s;
        dev_end && chain_ok && !halt_busy;
    endsequence
    sequence fetch_pci_s;
        in_fetch && grant && fetch_idx == 2'h1 && mem_rdata_in[`SCCE_W_PCI];
    endsequence

    steal_hold_a: assert property (mem_req_out && !mem_grant_in && !halt_busy && !dev_end
        |=> mem_req_out && $stable(mem_addr_out))
        else $error("Stolen cycle request dropped before its grant.");
    resp_limit_a: assert property (waiting && resp_cnt == RESP_CYC |=> overrun)
        else $error("Late service answer not recorded.");
    sense_int_a: assert property (fn_sense_int |=> xio_done_out
        && xio_accum_out[15] == $past(int_req))
        else $error("Sense interrupt answer wrong.");
    halt_idle_a: assert property (halt_idle |=> cu_halt_out
        && cu_dev_addr_out == $past(xio_modifier_in[`SCCE_MOD_DEV]))
        else $error("Idle halt did not reach the drive.");
    halt_xfer_a: assert property (halt_busy |=> idle && int_req && halted)
        else $error("Halt during operation did not end it.");
    sense_count_a: assert property (fn_sense && sw_sel == `SCCE_SW_COUNT
        |=> xio_accum_out == $past(count))
        else $error("Status word select wrong.");
    poll_stop_a: assert property (fn_sense && !op_end
        |=> poll_off == $past(xio_modifier_in[`SCCE_MOD_POLL]))
        else $error("Polling control not applied.");
    poll_latch_a: assert property (poll_hit |=> status_pending && int_req
        && unit_addr == $past(cu_unit_addr_in) && !poll_hit)
        else $error("Polled status not latched.");
    start_load_a: assert property (start_ok |=> in_fetch && fetch_idx == 2'h0
        && ccw_addr == $past(xio_address_in))
        else $error("Start did not begin the fetch.");
    pci_fetch_a: assert property (fetch_pci_s |=> int_req && pci_seen)
        else $error("Fetch interrupt flag ignored.");
    chain_step_a: assert property (chain_evt_s |=> in_fetch
        && ccw_addr == $past(ccw_addr) + ($past(cu_status_mod_in) ?
        `SCCE_CCW_SKIP_STEP : `SCCE_CCW_STEP))
        else $error("Chained command word address wrong.");
endmodule

// *** rtl/scce_decode.sv ***
// Command code classifier.
`include "scce_regs.svh"
module scce_decode (
    // Command code in, operation class out.
    input wire logic [7:0] cmd_in,
    output scce_pkg::scce_op_type op_out
);
    wire logic [1:0] low2 = cmd_in[`SCCE_CMD_LOW2];
    wire logic [3:0] low4 = cmd_in[`SCCE_CMD_LOW4];
    // The upper bits are modifiers for the device and do not change the class.
    assign op_out = low2 == `SCCE_CC_WRITE ? scce_pkg::OP_WRITE :
        low2 == `SCCE_CC_READ ? scce_pkg::OP_READ :
        low2 == `SCCE_CC_CONTROL ? scce_pkg::OP_CONTROL :
        low4 == `SCCE_CC_SENSE ? scce_pkg::OP_SENSE :
        low4 == `SCCE_CC_TIC ? scce_pkg::OP_TIC :
        low4 == `SCCE_CC_TEST ? scce_pkg::OP_TEST :
        low4 == `SCCE_CC_READ_BACK ? scce_pkg::OP_READ : scce_pkg::OP_INVALID;
endmodule

// *** rtl/scce_fifo.sv ***
// Byte buffer between the control unit and the storage packer.
module scce_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic flush_in,
    // Filling side.
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    // Draining side.
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("DEPTH must be a power of two of at least two.");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] rd;
    logic [AW:0] wr;
    wire logic full = rd[AW-1:0] == wr[AW-1:0] && rd[AW] != wr[AW];
    wire logic push = in_valid_in && !full;
    wire logic pop = out_valid_out && out_ready_in;
    assign in_ready_out = !full;
    assign out_valid_out = rd != wr;
    assign out_data_out = mem[rd[AW-1:0]];
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rd <= '0;
            wr <= '0;
        end else if (flush_in) begin
            rd <= '0;
            wr <= '0;
        end else begin
            rd <= rd + (AW + 1)'(pop);
            wr <= wr + (AW + 1)'(push);
        end
    end
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr[AW-1:0]] <= in_data_in;
        end
    end
endmodule
